/* File: rtl/sds_dev.sv */
// Sensor end: control register port and pixel stream port on one serial link
//
// Operation
// - Control words: 8 bits, MSB first, full duplex
// - Packet is command word then data words
// - Bit 7 set means command, clear data
// - Command: bit6 read, bits5-2 register address
// - Write data word carries 7-bit value
// - Read: dummy words clock register out
// - Triple registers return three words in turn
// - MISO always driven while word selected
// - Events raise interrupt; status read returns them
// - Host keeps control clock at most 200k
// - Acquisition pixels on MISO under pixel select
// - Each pixel byte carries two 4-bit pixels
// - Pixel port runs up to 16 Mbps
// - Frame: one dummy column, 232 real
// - Four bytes per column, columns in order
// - Even pixel first; sync reads F0F00200
// - First frame preceded by 40 dummy clocks
// - Host aligns frames on sync pattern
// - Host repeats frame reads at steady rate
// - SCK idles high; shift out fall, sample rise
// - Bad pulse count desyncs; read-only writes ignored
// - Navigation read returns three, then clears
`timescale 1ns/1ps
module sds_dev
    import sds_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial link
    sds_if.dev bus,
    // Read-only register loading from the sensing logic
    input wire logic ro_wr_i,
    input wire logic [ADDR_W-1:0] ro_addr_i,
    input wire logic [7:0] ro_data_i,
    // Register write notification and acquisition mode
    output logic cfg_wr_o,
    output logic [ADDR_W-1:0] cfg_addr_o,
    output logic [7:0] cfg_data_o,
    output logic acq_mode_o,
    // Pixel source
    output logic [PIDX_W-1:0] pix_addr_o,
    input wire logic [7:0] pix_byte_i
);

    typedef struct packed {
        logic sck1, sck2, sck3;
        logic mosi1, mosi2;
        logic cs1, cs2;
        logic ps1, ps2;
        sds_ctl_t st;
        logic [2:0] cbit;
        logic [7:0] rxsh;
        logic [7:0] txsh;
        logic [ADDR_W-1:0] addr;
        logic [1:0] rd_idx;
        logic [NREGS-1:0][7:0] regs;
        logic miso;
        logic miso_oe;
        logic irq;
        logic cfg_wr;
        logic [7:0] cfg_data;
        logic [5:0] pwarm;
        logic [2:0] pbit;
        logic [PIDX_W-1:0] pidx;
        logic [7:0] ptx;
    } sds_dev_state_t;

    sds_dev_state_t r;
    sds_dev_state_t next_r;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Status and everything from the navigation block upward are read-only
    function automatic logic is_ro(input logic [ADDR_W-1:0] a);
        return (a == ADDR_STATUS) || (a >= ADDR_RO_FIRST);
    endfunction

    function automatic logic is_triple(input logic [ADDR_W-1:0] a);
        return (a == ADDR_NAV) || (a == ADDR_CLICK_PIX);
    endfunction

    // Frame byte: the dummy column is the fixed sync word, then pixel bytes
    function automatic logic [7:0] frame_byte(input logic [PIDX_W-1:0] idx, input logic [7:0] pix);
        logic [7:0] b;
        b = pix;
        if (idx < PIDX_W'(COL_BYTES)) begin
            b = SYNC_WORD[8'(31 - 8 * idx) -: 8];
        end
        return b;
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic csel;
        logic psel;
        logic acq;
        logic [7:0] word;
        logic [7:0] pb;
        logic [ADDR_W-1:0] na;
        rise = 1'b0;
        fall = 1'b0;
        csel = 1'b0;
        psel = 1'b0;
        acq = 1'b0;
        word = 8'h00;
        pb = 8'h00;
        na = '0;
        next_r = r;

        // Pins from the host pass two flops before use
        next_r.sck1 = bus.sck;
        next_r.sck2 = r.sck1;
        next_r.sck3 = r.sck2;
        next_r.mosi1 = bus.mosi;
        next_r.mosi2 = r.mosi1;
        next_r.cs1 = bus.control_port_select_n;
        next_r.cs2 = r.cs1;
        next_r.ps1 = bus.pixel_port_select_n;
        next_r.ps2 = r.ps1;

        rise = r.sck2 & ~r.sck3;
        fall = ~r.sck2 & r.sck3;
        csel = ~r.cs2;
        psel = ~r.ps2;
        acq = r.regs[ADDR_MODE][ACQ_BIT];
        next_r.cfg_wr = 1'b0;
        next_r.miso_oe = csel | psel;

        // Control port: bit counter survives deselect, so a short word desyncs
        if (csel) begin
            if (fall) begin
                next_r.miso = r.txsh[7];
                next_r.txsh = {r.txsh[6:0], 1'b0};
            end
            if (rise) begin
                word = {r.rxsh[6:0], r.mosi2};
                next_r.rxsh = word;
                next_r.cbit = r.cbit + 3'd1;
                if (r.cbit == 3'd7) begin
                    if (word[CMD_BIT]) begin
                        next_r.addr = word[ADDR_MSB:ADDR_LSB];
                        next_r.rd_idx = 2'd0;
                        if (word[RW_BIT]) begin
                            next_r.st = CTL_RD;
                            next_r.txsh = r.regs[word[ADDR_MSB:ADDR_LSB]];
                            if (word[ADDR_MSB:ADDR_LSB] == ADDR_STATUS) begin
                                next_r.regs[ADDR_STATUS] = REG_RST;
                            end
                        end else begin
                            next_r.st = CTL_WR;
                        end
                    end else begin
                        case (r.st)
                            CTL_WR: begin
                                if (!is_ro(r.addr)) begin
                                    next_r.regs[r.addr] = {1'b0, word[6:0]};
                                    next_r.cfg_wr = 1'b1;
                                    next_r.cfg_data = {1'b0, word[6:0]};
                                end
                                next_r.st = CTL_CMD;
                            end
                            CTL_RD: begin
                                if (is_triple(r.addr) && r.rd_idx != TRIPLE_LAST) begin
                                    next_r.rd_idx = r.rd_idx + 2'd1;
                                    na = r.addr + ADDR_W'(r.rd_idx) + 4'h1;
                                    next_r.txsh = r.regs[na];
                                end else begin
                                    if (r.addr == ADDR_NAV) begin
                                        next_r.regs[ADDR_NAV] = NAV_GEN_RST;
                                        next_r.regs[ADDR_NAV + 4'h1] = REG_RST;
                                        next_r.regs[ADDR_NAV + 4'h2] = REG_RST;
                                    end
                                    next_r.txsh = next_r.regs[r.addr];
                                end
                            end
                            default: next_r.st = CTL_CMD;
                        endcase
                    end
                end
            end
        end

        // Pixel port: warm-up then frames back to back while selected
        if (!acq) begin
            next_r.pwarm = 6'd0;
            next_r.pbit = 3'd0;
            next_r.pidx = '0;
        end else if (psel && fall) begin
            if (r.pwarm != WARM_CLKS) begin
                next_r.pwarm = r.pwarm + 6'd1;
                next_r.miso = 1'b0;
            end else begin
                if (r.pbit == 3'd0) begin
                    pb = frame_byte(r.pidx, pix_byte_i);
                    next_r.miso = pb[7];
                    next_r.ptx = {pb[6:0], 1'b0};
                    if (r.pidx == PIDX_W'(FRAME_BYTES - 1)) begin
                        next_r.pidx = '0;
                    end else begin
                        next_r.pidx = r.pidx + PIDX_W'(1);
                    end
                end else begin
                    next_r.miso = r.ptx[7];
                    next_r.ptx = {r.ptx[6:0], 1'b0};
                end
                next_r.pbit = r.pbit + 3'd1;
            end
        end

        // Loads from the sensing logic; status bits are sticky and beat a clear
        if (ro_wr_i) begin
            if (ro_addr_i == ADDR_STATUS) begin
                next_r.regs[ADDR_STATUS] = next_r.regs[ADDR_STATUS] | ro_data_i;
            end else begin
                next_r.regs[ro_addr_i] = ro_data_i;
            end
        end
        next_r.irq = |next_r.regs[ADDR_STATUS];
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.sck1 <= 1'b1;
            r.sck2 <= 1'b1;
            r.sck3 <= 1'b1;
            r.cs1 <= 1'b1;
            r.cs2 <= 1'b1;
            r.ps1 <= 1'b1;
            r.ps2 <= 1'b1;
            r.st <= CTL_CMD;
            r.regs[ADDR_NAV] <= NAV_GEN_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign bus.miso = r.miso;
    assign bus.miso_oe = r.miso_oe;
    assign bus.irq = r.irq;
    assign cfg_wr_o = r.cfg_wr;
    assign cfg_addr_o = r.addr;
    assign cfg_data_o = r.cfg_data;
    assign acq_mode_o = r.regs[ADDR_MODE][ACQ_BIT];
    assign pix_addr_o = r.pidx;

endmodule

/* File: rtl/sds_host.sv */
// Host end: SPI master that makes SCK by division and moves one byte per request
`timescale 1ns/1ps
module sds_host
    import sds_pkg::*;
#(
    parameter int CTRL_HALF = CTRL_HALF_CYC,
    parameter int PIX_HALF = PIX_HALF_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial link
    sds_if.host bus,
    // Byte request
    input wire logic xfer_valid_i,
    input wire logic xfer_pixel_i,
    input wire logic xfer_last_i,
    input wire logic [7:0] xfer_byte_i,
    output logic xfer_ready_o,
    // Byte answer and event
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o,
    output logic irq_o
);

    typedef struct packed {
        sds_hst_t st;
        logic [HALF_W-1:0] cnt;
        logic [2:0] bits;
        logic sck;
        logic mosi;
        logic csn;
        logic psn;
        logic pixel;
        logic last;
        logic ready;
        logic [7:0] tx;
        logic [7:0] rx;
        logic rx_valid;
        logic miso1, miso2;
        logic irq1, irq2;
    } sds_host_state_t;

    sds_host_state_t r;
    sds_host_state_t next_r;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic done;
        logic [HALF_W-1:0] half;
        next_r = r;
        half = r.pixel ? HALF_W'(PIX_HALF) : HALF_W'(CTRL_HALF);
        done = (r.cnt == half - HALF_W'(1));
        next_r.miso1 = bus.miso_line;
        next_r.miso2 = r.miso1;
        next_r.irq1 = bus.irq;
        next_r.irq2 = r.irq1;
        next_r.rx_valid = 1'b0;
        next_r.cnt = done ? '0 : r.cnt + HALF_W'(1);
        case (r.st)
            H_IDLE: begin
                next_r.cnt = '0;
                if (xfer_valid_i) begin
                    next_r.tx = xfer_byte_i;
                    next_r.pixel = xfer_pixel_i;
                    next_r.last = xfer_last_i;
                    next_r.ready = 1'b0;
                    next_r.csn = xfer_pixel_i;
                    next_r.psn = ~xfer_pixel_i;
                    next_r.st = H_SETUP;
                end
            end
            H_SETUP: begin
                if (done) begin
                    next_r.sck = 1'b0;
                    next_r.mosi = r.tx[7];
                    next_r.tx = {r.tx[6:0], 1'b0};
                    next_r.st = H_LOW;
                end
            end
            H_LOW: begin
                if (done) begin
                    next_r.rx = {r.rx[6:0], r.miso2};
                    next_r.sck = 1'b1;
                    next_r.st = H_HIGH;
                end
            end
            H_HIGH: begin
                if (done) begin
                    next_r.bits = r.bits + 3'd1;
                    if (r.bits == 3'd7) begin
                        next_r.rx_valid = 1'b1;
                        next_r.st = r.last ? H_HOLD : H_GAP;
                        next_r.ready = ~r.last;
                    end else begin
                        next_r.sck = 1'b0;
                        next_r.mosi = r.tx[7];
                        next_r.tx = {r.tx[6:0], 1'b0};
                        next_r.st = H_LOW;
                    end
                end
            end
            H_GAP: begin
                next_r.cnt = '0;
                if (xfer_valid_i) begin
                    next_r.ready = 1'b0;
                    next_r.last = xfer_last_i;
                    next_r.sck = 1'b0;
                    next_r.mosi = xfer_byte_i[7];
                    next_r.tx = {xfer_byte_i[6:0], 1'b0};
                    next_r.st = H_LOW;
                end
            end
            H_HOLD: begin
                if (done) begin
                    next_r.csn = 1'b1;
                    next_r.psn = 1'b1;
                    next_r.ready = 1'b1;
                    next_r.st = H_IDLE;
                end
            end
            default: next_r.st = H_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.st <= H_IDLE;
            r.sck <= 1'b1;
            r.csn <= 1'b1;
            r.psn <= 1'b1;
            r.ready <= 1'b1;
            r.miso1 <= 1'b1;
            r.miso2 <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign bus.sck = r.sck;
    assign bus.mosi = r.mosi;
    assign bus.control_port_select_n = r.csn;
    assign bus.pixel_port_select_n = r.psn;
    assign xfer_ready_o = r.ready;
    assign rx_valid_o = r.rx_valid;
    assign rx_byte_o = r.rx;
    assign irq_o = r.irq2;

endmodule

/* File: shared/sds_if.sv */
// Serial link between the sensor port and its host master
`timescale 1ns/1ps
interface sds_if;
    logic sck;
    logic mosi;
    logic control_port_select_n;
    logic pixel_port_select_n;
    logic miso;
    logic miso_oe;
    logic irq;
    logic miso_line;

    // Released line floats high through the board pull-up
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev (
        input sck,
        input mosi,
        input control_port_select_n,
        input pixel_port_select_n,
        output miso,
        output miso_oe,
        output irq
    );
    modport host (
        output sck,
        output mosi,
        output control_port_select_n,
        output pixel_port_select_n,
        input miso_line,
        input irq
    );
endinterface

/* File: shared/sds_pkg.sv */
// Shared constants and types for the dual serial slave port and its host end
package sds_pkg;

    // ----------------------------------------------------------------
    // Clocking and serial rates
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 250_000_000;
    localparam int CTRL_MAX_BPS = 200_000;
    localparam int PIX_MAX_BPS = 16_000_000;
    // Least half period of SCK, rounded up to whole system clocks
    localparam int CTRL_HALF_CYC = (CLK_HZ + 2 * CTRL_MAX_BPS - 1) / (2 * CTRL_MAX_BPS);
    localparam int PIX_HALF_CYC = (CLK_HZ + 2 * PIX_MAX_BPS - 1) / (2 * PIX_MAX_BPS);
    localparam int HALF_W = 10;

    // ----------------------------------------------------------------
    // Control word layout
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 8;
    localparam int CMD_BIT = 7;
    localparam int RW_BIT = 6;
    localparam int ADDR_MSB = 5;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_W = 4;
    localparam int NREGS = 16;

    // ----------------------------------------------------------------
    // Register addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h1;
    localparam logic [3:0] ADDR_NAV = 4'h8;
    localparam logic [3:0] ADDR_CLICK_PIX = 4'hC;
    localparam logic [3:0] ADDR_RO_FIRST = 4'h8;
    localparam logic [7:0] NAV_GEN_RST = 8'h08;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int ACQ_BIT = 0;
    localparam logic [1:0] TRIPLE_LAST = 2'h2;

    // ----------------------------------------------------------------
    // Pixel frame
    // ----------------------------------------------------------------
    localparam int FRAME_COLS = 233;
    localparam int COL_BYTES = 4;
    localparam int FRAME_BYTES = FRAME_COLS * COL_BYTES;
    localparam int PIDX_W = 10;
    localparam logic [5:0] WARM_CLKS = 6'd40;
    localparam logic [31:0] SYNC_WORD = 32'hF0F00200;

    typedef enum logic [1:0] {CTL_CMD, CTL_WR, CTL_RD} sds_ctl_t;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_GAP, H_HOLD} sds_hst_t;

endpackage

/* File: sim/sds_monitor.sv */
// Concurrent checks on the serial link between the sensor end and the host end
`timescale 1ns/1ps
module sds_monitor #(
    parameter int HALF = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link signals
    input wire logic sck,
    input wire logic mosi,
    input wire logic control_port_select_n,
    input wire logic pixel_port_select_n,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic irq,
    input wire logic miso_line
);
    // ----------------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------------
    logic sck_q;
    int low_cnt;
    int rise_cnt;

    // Low phase length and rises per control frame; a bare repetition cannot hold a parameter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_q <= 1'b1;
            low_cnt <= 0;
            rise_cnt <= 0;
        end else begin
            sck_q <= sck;
            low_cnt <= sck ? 0 : low_cnt + 1;
            rise_cnt <= control_port_select_n ? 0 : rise_cnt + ((sck && !sck_q) ? 1 : 0);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_sck_idle_high: assert property (control_port_select_n && pixel_port_select_n |-> sck)
        else $error("serial clock low outside a frame");
    a_single_port: assert property (!(!control_port_select_n && !pixel_port_select_n))
        else $error("both port selects low");
    a_miso_released: assert property ((control_port_select_n && pixel_port_select_n)[*6] |-> !miso_oe)
        else $error("miso driven while deselected");
    a_ctrl_miso_driven: assert property ((!control_port_select_n)[*6] |-> miso_oe)
        else $error("miso not driven during control word");
    a_miso_after_fall: assert property ($fell(sck) |-> $stable(miso) ##1 $stable(miso))
        else $error("miso changed at the falling edge itself");
    a_mosi_at_rise: assert property ($rose(sck) && !control_port_select_n |->
        $stable(mosi) ##1 $stable(mosi))
        else $error("mosi changed around the sampling edge");
    // A steady low phase keeps the pixel integration time constant
    a_sck_low_half: assert property ($rose(sck) |-> low_cnt == HALF)
        else $error("serial clock low phase length wrong");
    a_word_eight_bits: assert property ($rose(control_port_select_n) |-> rise_cnt % 8 == 0)
        else $error("control frame not a whole number of bytes");

    // Main scenarios reached
    c_ctrl_packet: cover property ($rose(control_port_select_n));
    c_pixel_frame: cover property (!pixel_port_select_n && miso_oe);
    c_irq_raised: cover property ($rose(irq) && miso_line);
endmodule

/* File: sim/sensor_dual_spi_slave_port_tb.sv */
// Self-checking bench: host end drives the sensor end across the shared link
`timescale 1ns/1ps
module sensor_dual_spi_slave_port_tb;
    import sds_pkg::*;

    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic xfer_valid_i = 1'b0;
    logic xfer_pixel_i = 1'b0;
    logic xfer_last_i = 1'b0;
    logic [7:0] xfer_byte_i = 8'h00;
    logic ro_wr_i = 1'b0;
    logic [ADDR_W-1:0] ro_addr_i = 4'h0;
    logic [7:0] ro_data_i = 8'h00;
    logic [7:0] salt = 8'h00;
    logic [7:0] pix_byte_i;
    logic xfer_ready_o, rx_valid_o, irq_o, cfg_wr_o, acq_mode_o;
    logic [7:0] rx_byte_o, cfg_data_o, rx, wr_data;
    logic [ADDR_W-1:0] cfg_addr_o, wr_addr;
    logic [PIDX_W-1:0] pix_addr_o;
    int fails = 0;
    int tests_run = 0;
    int wr_cnt = 0;

    sds_if link();
    sds_dev sds_dev_i (.clk_i(clk_i), .rst_i(rst_i), .bus(link), .ro_wr_i(ro_wr_i), .ro_addr_i(ro_addr_i),
        .ro_data_i(ro_data_i), .cfg_wr_o(cfg_wr_o), .cfg_addr_o(cfg_addr_o), .cfg_data_o(cfg_data_o),
        .acq_mode_o(acq_mode_o), .pix_addr_o(pix_addr_o), .pix_byte_i(pix_byte_i));
    sds_host #(.CTRL_HALF(8), .PIX_HALF(8)) sds_host_i (.clk_i(clk_i), .rst_i(rst_i), .bus(link),
        .xfer_valid_i(xfer_valid_i), .xfer_pixel_i(xfer_pixel_i), .xfer_last_i(xfer_last_i),
        .xfer_byte_i(xfer_byte_i), .xfer_ready_o(xfer_ready_o), .rx_valid_o(rx_valid_o),
        .rx_byte_o(rx_byte_o), .irq_o(irq_o));
    sds_monitor #(.HALF(8)) sds_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .sck(link.sck), .mosi(link.mosi),
        .control_port_select_n(link.control_port_select_n), .pixel_port_select_n(link.pixel_port_select_n),
        .miso(link.miso), .miso_oe(link.miso_oe), .irq(link.irq), .miso_line(link.miso_line));

    // Pixel source: byte content depends on index so order slips show up
    assign pix_byte_i = pix_addr_o[7:0] ^ salt;

    // 250 MHz system clock
    always #2 clk_i = ~clk_i;

    // Record each register write; sampled mid-cycle, clear of the edge that launches the pulse
    always @(negedge clk_i) begin
        if (cfg_wr_o === 1'b1) begin
            wr_cnt++;
            wr_addr = cfg_addr_o;
            wr_data = cfg_data_o;
        end
    end

    // ----------------------------------------------------------------
    // Tasks and expectations
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    // One byte through the host; bounded waits on its own handshake
    task automatic xfer(input logic pix, input logic last, input logic [7:0] b, output logic [7:0] r);
        int n;
        n = 0;
        @(negedge clk_i);
        xfer_valid_i = 1'b1;
        xfer_pixel_i = pix;
        xfer_last_i = last;
        xfer_byte_i = b;
        while (xfer_ready_o !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        xfer_valid_i = 1'b0;
        while (rx_valid_o !== 1'b1 && n < 800) begin
            @(negedge clk_i);
            n++;
        end
        chk("byte answer", 8'h01, {7'h00, rx_valid_o});
        r = rx_byte_o;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [6:0] v);
        xfer(1'b0, 1'b0, {2'b10, a, 2'b11}, rx);
        xfer(1'b0, 1'b1, {1'b0, v}, rx);
        repeat (12) @(negedge clk_i);
    endtask

    // Command then three dummy words with random don't-care bits
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] q [3]);
        xfer(1'b0, 1'b0, {2'b11, a, 2'($urandom)}, rx);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, i == 2, {1'b0, 7'($urandom)}, q[i]);
        end
        repeat (12) @(negedge clk_i);
    endtask

    task automatic ro_load(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_i);
        ro_wr_i = 1'b1;
        ro_addr_i = a;
        ro_data_i = d;
        @(negedge clk_i);
        ro_wr_i = 1'b0;
    endtask

    // Five warm-up bytes, then sync column, then frame bytes in index order
    function automatic logic [7:0] exp_pix(input int i);
        int j;
        j = i - 5;
        if (i < 5) begin
            return 8'h00;
        end else if (j < 4) begin
            return SYNC_WORD[31 - 8 * j -: 8];
        end
        return 8'(j) ^ salt;
    endfunction

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #200000;
        fails++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] q [3];
        logic [7:0] v [3];
        logic [6:0] w;
        logic [3:0] b;
        int n0;
        int n;
        void'($urandom(32'hCC51));
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        chk("idle wire", 8'h03, {6'h00, link.sck, link.control_port_select_n});
        $display("test reset done");
        // Writable registers written then read back twice
        for (int a = 1; a < 8; a++) begin
            w = 7'($urandom);
            if (a == 1) w[0] = 1'b0;
            n0 = wr_cnt;
            wr_reg(4'(a), w);
            chk("write count", 8'(n0 + 1), 8'(wr_cnt));
            chk("write addr", 8'(a), {4'h0, wr_addr});
            chk("write data", {1'b0, w}, wr_data);
            rd_reg(4'(a), q);
            chk("read first", {1'b0, w}, q[0]);
            chk("read again", {1'b0, w}, q[1]);
        end
        $display("test write_read done");
        // Writes to read-only places leave no trace
        foreach (v[i]) begin
            b = (i == 0) ? 4'h0 : ((i == 1) ? 4'h8 : 4'hF);
            n0 = wr_cnt;
            wr_reg(b, 7'($urandom));
            chk("ro write ignored", 8'(n0), 8'(wr_cnt));
        end
        $display("test read_only done");
        // Event bits accumulate, raise the interrupt, and a status read clears it
        ro_load(ADDR_STATUS, 8'h80);
        ro_load(ADDR_STATUS, 8'h01);
        n = 0;
        while (irq_o !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        chk("irq raised", 8'h01, {7'h00, irq_o});
        rd_reg(ADDR_STATUS, q);
        chk("status", 8'h81, q[0]);
        chk("irq cleared", 8'h00, {7'h00, irq_o});
        $display("test interrupt done");
        // Triple registers return in turn; navigation clears after reading
        for (int t = 0; t < 2; t++) begin
            b = (t == 0) ? ADDR_NAV : ADDR_CLICK_PIX;
            foreach (v[i]) begin
                v[i] = 8'($urandom);
                ro_load(b + 4'(i), v[i]);
            end
            rd_reg(b, q);
            foreach (v[i]) chk("triple read", v[i], q[i]);
        end
        rd_reg(ADDR_NAV, q);
        chk("nav cleared 0", NAV_GEN_RST, q[0]);
        chk("nav cleared 1", 8'h00, q[1]);
        chk("nav cleared 2", 8'h00, q[2]);
        $display("test triples done");
        // Acquisition: warm-up, sync column, then frame bytes
        wr_reg(ADDR_MODE, 7'h01);
        chk("acq on", 8'h01, {7'h00, acq_mode_o});
        salt = 8'($urandom);
        for (int i = 0; i < 25; i++) begin
            xfer(1'b1, i == 24, 8'h00, rx);
            chk("pixel byte", exp_pix(i), rx);
        end
        wr_reg(ADDR_MODE, 7'h00);
        chk("acq off", 8'h00, {7'h00, acq_mode_o});
        $display("test pixel done");
        end_of_test();
    end
endmodule
